/* File: bsc_burst_ctrl.sv */
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none

`include "bsc_cfg.svh"

module bsc_burst_ctrl
	import bsc_pkg::*;
#(
	parameter int BURST_CYCLES = `BSC_BURST_CYCLES,
	parameter int SETTLE_HALF  = `BSC_SETTLE_HALF,
	parameter int CW           = 12
) (
	input  wire logic        mclk_i,
	input  wire logic        srst_i,
	input  wire logic [1:0]  drain_sense_inputs_i,
	input  wire logic        conduct_i,
	input  wire logic        half_cycle_end_i,
	input  wire logic        supply_ok_i,
	input  wire logic [1:0]  en_strap_i,
	input  wire logic [1:0]  sel_strap_i,
	input  wire logic        remote_off_i,
	input  wire logic        remote_on_i,
	input  wire logic        sleep_request_i,
	output logic             gate_drive_en_o,
	output logic             low_power_o,
	output logic             en_source_startup_o,
	output logic             en_source_run_o,
	output logic             select_pin_source_current_o,
	output logic             sleep_enabled_o,
	output logic [6:0]       sleep_entry_duty_o,
	output logic [6:0]       burst_exit_duty_o,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o
);
	localparam int BW = $clog2(BURST_CYCLES + 1);
	localparam int SW = $clog2(SETTLE_HALF + 1);

	bsc_state_type state;
	bsc_state_type next_state;
	logic [BW-1:0] burst_cnt;
	logic          burst_hit;
	logic [SW-1:0] settle_cnt;
	logic [7:0]    credit_acc;
	logic [7:0]    next_credit;
	logic          exit_hit;
	logic          remote_stop;
	logic          supply_q;
	logic          cfg_valid;
	logic          soft_off;
	logic [7:0]    exit_credit;
	logic [6:0]    last_duty;
	logic          wb_req;

	bsc_meter_if meter_bus ();

	assign meter_bus.conduct   = conduct_i;
	assign meter_bus.cycle_end = half_cycle_end_i;

	bsc_duty_meter #(
		.CW (CW)
	) u_meter (
		.mclk_i (mclk_i),
		.srst_i (srst_i),
		.m      (meter_bus.meter)
	);

	// ------------------------------------------------------------------
	// Startup strap capture
	// ------------------------------------------------------------------
	// Straps are caught on the clocked rising edge of supply_ok, never in
	// reset; the remote switch must be open then, or the strap reads low.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			supply_q           <= 1'b0;
			cfg_valid          <= 1'b0;
			sleep_enabled_o    <= 1'b0;
			sleep_entry_duty_o <= '0;
			burst_exit_duty_o  <= '0;
		end else begin
			supply_q <= supply_ok_i;
			if (!supply_ok_i) begin
				cfg_valid <= 1'b0;
			end else if (!supply_q && !cfg_valid) begin
				cfg_valid          <= 1'b1;
				sleep_enabled_o    <= !en_strap_i[1];
				sleep_entry_duty_o <= entry_of(en_strap_i);
				burst_exit_duty_o  <= exit_of(en_strap_i, sel_strap_i);
			end
		end
	end

	function automatic logic [6:0] entry_of(input logic [1:0] en);
		if (en == en_low_res)
			return `BSC_ENTRY_LOW_RES;
		else if (en == en_high_res)
			return `BSC_ENTRY_HIGH_RES;
		else
			return 7'h00;
	endfunction

	function automatic logic [6:0] exit_of(input logic [1:0] en,
		input logic [1:0] sel);
		logic [6:0] v;
		v = 7'h00;
		case (en)
			en_low_res: begin
				case (sel)
					sel_short: v = `BSC_EXIT_A_SHORT;
					sel_100k:  v = `BSC_EXIT_A_100K;
					sel_180k:  v = `BSC_EXIT_A_180K;
					default:   v = `BSC_EXIT_A_OPEN;
				endcase
			end
			en_high_res: begin
				case (sel)
					sel_short: v = `BSC_EXIT_B_SHORT;
					sel_100k:  v = `BSC_EXIT_B_100K;
					sel_180k:  v = `BSC_EXIT_B_180K;
					default:   v = `BSC_EXIT_B_OPEN;
				endcase
			end
			default: begin
				case (sel)
					sel_short: v = `BSC_EXIT_D_SHORT;
					sel_100k:  v = `BSC_EXIT_D_100K;
					sel_180k:  v = `BSC_EXIT_D_180K;
					default:   v = `BSC_EXIT_D_OPEN;
				endcase
			end
		endcase
		return v;
	endfunction

	// Startup sources until latched, then run level / off
	assign en_source_startup_o         = !cfg_valid;
	assign en_source_run_o             = cfg_valid;
	assign select_pin_source_current_o = !cfg_valid;

	// ------------------------------------------------------------------
	// Burst idle detection
	// ------------------------------------------------------------------
	// Pauses shorter than the window are not seen as bursts; the primary
	// side must idle for at least the whole window for detection to work.
	always_ff @(posedge mclk_i) begin
		if (srst_i || !(&drain_sense_inputs_i)) begin
			burst_cnt <= '0;
		end else if (burst_cnt != BW'(BURST_CYCLES)) begin
			burst_cnt <= burst_cnt + 1'b1;
		end
	end

	assign burst_hit = (burst_cnt == BW'(BURST_CYCLES));

	// ------------------------------------------------------------------
	// Remote on-off with hysteresis
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (srst_i)
			remote_stop <= 1'b0;
		else if (remote_off_i)
			remote_stop <= 1'b1;
		else if (remote_on_i)
			remote_stop <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Exit credit: each half cycle above threshold adds its duty excess
	// ------------------------------------------------------------------
	// A cycle at or below threshold discards all credit, so only a run of
	// consecutive cycles above it leads out of low power.
	always_comb begin
		next_credit = 8'h00;
		exit_hit    = 1'b0;
		if (meter_bus.duty_valid
			&& meter_bus.duty_pct > burst_exit_duty_o) begin
			next_credit = sat_add(credit_acc,
				{1'b0, meter_bus.duty_pct - burst_exit_duty_o});
			exit_hit    = (next_credit >= exit_credit);
		end else if (!meter_bus.duty_valid) begin
			next_credit = credit_acc;
		end
	end

	function automatic logic [7:0] sat_add(input logic [7:0] a,
		input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[8] ? 8'hff : s[7:0];
	endfunction

	always_ff @(posedge mclk_i) begin
		if (srst_i || state != s_low)
			credit_acc <= '0;
		else
			credit_acc <= next_credit;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i)
			last_duty <= '0;
		else if (meter_bus.duty_valid)
			last_duty <= meter_bus.duty_pct;
	end

	// ------------------------------------------------------------------
	// Operating state
	// ------------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			s_startup: begin
				if (cfg_valid)
					next_state = s_run;
			end
			s_run: begin
				if (burst_hit || remote_stop || soft_off)
					next_state = s_low;
				else if (sleep_request_i && sleep_enabled_o)
					next_state = s_low;
			end
			s_low: begin
				if (!remote_stop && !soft_off && !burst_hit && exit_hit)
					next_state = s_settle;
			end
			s_settle: begin
				if (burst_hit || remote_stop || soft_off)
					next_state = s_low;
				else if (settle_cnt == SW'(SETTLE_HALF))
					next_state = s_run;
			end
			default: next_state = s_startup;
		endcase
		if (!cfg_valid)
			next_state = s_startup;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i)
			state <= s_startup;
		else
			state <= next_state;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i || state != s_settle)
			settle_cnt <= '0;
		else if (half_cycle_end_i && settle_cnt != SW'(SETTLE_HALF))
			settle_cnt <= settle_cnt + 1'b1;
	end

	assign gate_drive_en_o = (state == s_run);
	assign low_power_o     = (state == s_low);

	// ------------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------------
	// One wait state: ack is registered, so every access takes two edges.
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge mclk_i) begin
		if (srst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_req;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			soft_off    <= 1'b0;
			exit_credit <= `BSC_CREDIT_RESET;
		end else if (wb_req && wb_we_i && wb_adr_i == `BSC_ADR_CTRL) begin
			if (wb_sel_i[0])
				soft_off <= wb_dat_i[`BSC_CTRL_SOFT_OFF];
			if (wb_sel_i[1])
				exit_credit <=
					wb_dat_i[`BSC_CTRL_CREDIT_MSB:`BSC_CTRL_CREDIT_LSB];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			wb_dat_o <= '0;
		end else if (wb_req && !wb_we_i) begin
			if (wb_adr_i == `BSC_ADR_CTRL)
				wb_dat_o <= {16'h0000, exit_credit, 7'h00, soft_off};
			else if (wb_adr_i == `BSC_ADR_STATUS)
				wb_dat_o <= {9'h000, burst_exit_duty_o, 1'b0,
					sleep_entry_duty_o, remote_stop, burst_hit,
					sleep_enabled_o, cfg_valid, state};
			else if (wb_adr_i == `BSC_ADR_DUTY)
				wb_dat_o <= {8'h00, credit_acc, 9'h000, last_duty};
			else
				wb_dat_o <= '0;
		end
	end

endmodule

`default_nettype wire

/* File: bsc_burst_ctrl_assertions.sv */
`timescale 1ns/100ps
`default_nettype none

module bsc_burst_ctrl_assertions
	import bsc_pkg::*;
#(
	parameter int BURST_CYCLES = 1000,
	parameter int SETTLE_HALF  = 24
) (
	input wire logic       mclk_i,
	input wire logic       srst_i,
	input wire logic [1:0] drain_sense_inputs_i,
	input wire logic       half_cycle_end_i,
	input wire logic       supply_ok_i,
	input wire logic [1:0] en_strap_i,
	input wire logic [1:0] sel_strap_i,
	input wire logic       remote_off_i,
	input wire logic       gate_drive_en_o,
	input wire logic       low_power_o,
	input wire logic       en_source_startup_o,
	input wire logic       en_source_run_o,
	input wire logic       select_pin_source_current_o,
	input wire logic       sleep_enabled_o,
	input wire logic [6:0] sleep_entry_duty_o,
	input wire logic [6:0] burst_exit_duty_o
);
	int   arm_cnt;
	int   half_cnt;
	logic seen_low;

	// ------------------------------------------------------------------
	// Helper counters
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (srst_i || drain_sense_inputs_i != 2'h3)
			arm_cnt <= 0;
		else if (arm_cnt < 4095)
			arm_cnt <= arm_cnt + 1;
	end
	// Counts only while neither low nor driving, i.e. settling or in startup
	always_ff @(posedge mclk_i) begin
		if (srst_i || low_power_o || gate_drive_en_o)
			half_cnt <= 0;
		else if (half_cycle_end_i)
			half_cnt <= half_cnt + 1;
	end
	always_ff @(posedge mclk_i) begin
		if (srst_i || en_source_startup_o || gate_drive_en_o)
			seen_low <= 1'b0;
		else if (low_power_o)
			seen_low <= 1'b1;
	end

	function automatic logic [6:0] exit_of(input logic [1:0] e,
			input logic [1:0] s);
		logic [6:0] b;
		b = (s == 2'h0) ? 7'd80 : (s == 2'h1) ? 7'd75 :
			(s == 2'h2) ? 7'd65 : 7'd60;
		if (e[1] && s == 2'h3)
			return 7'd0;
		return (e == 2'h1) ? b - 7'd5 : b;
	endfunction

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	sequence s_cfg_taken;
		$rose(en_source_run_o);
	endsequence
	sequence s_resumed;
		$rose(gate_drive_en_o) ##0 seen_low;
	endsequence

	a_gate_off_low: assert property (@(posedge mclk_i) disable iff (srst_i)
		low_power_o |-> !gate_drive_en_o ##1 !gate_drive_en_o)
		else $error("gate on in low");
	a_burst_entry: assert property (@(posedge mclk_i) disable iff (srst_i)
		arm_cnt >= BURST_CYCLES + 3 |-> !gate_drive_en_o)
		else $error("idle not detected");
	a_cfg_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
		supply_ok_i && $past(supply_ok_i) && en_source_run_o
		&& $past(en_source_run_o) |-> $stable(burst_exit_duty_o)
		&& $stable(sleep_enabled_o) && $stable(sleep_entry_duty_o))
		else $error("config moved");
	a_src_run: assert property (@(posedge mclk_i) disable iff (srst_i)
		en_source_run_o |-> !en_source_startup_o
		&& !select_pin_source_current_o) else $error("sources wrong");
	a_src_drop: assert property (@(posedge mclk_i) disable iff (srst_i)
		!supply_ok_i |=> en_source_startup_o && select_pin_source_current_o)
		else $error("sources not restored");
	a_exit_table: assert property (@(posedge mclk_i) disable iff (srst_i)
		s_cfg_taken |-> burst_exit_duty_o
		== exit_of($past(en_strap_i), $past(sel_strap_i)))
		else $error("exit duty wrong");
	a_entry_table: assert property (@(posedge mclk_i) disable iff (srst_i)
		s_cfg_taken |-> sleep_enabled_o == !$past(en_strap_i[1])
		&& sleep_entry_duty_o == ($past(en_strap_i) == 2'h0 ? 7'd40
		: $past(en_strap_i) == 2'h1 ? 7'd25 : 7'd0))
		else $error("entry config wrong");
	a_settle_wait: assert property (@(posedge mclk_i) disable iff (srst_i)
		s_resumed |-> half_cnt >= SETTLE_HALF) else $error("settle short");
	a_remote_stop: assert property (@(posedge mclk_i) disable iff (srst_i)
		remote_off_i |-> ##[1:2] !gate_drive_en_o)
		else $error("remote off ignored");
endmodule

bind bsc_burst_ctrl bsc_burst_ctrl_assertions #(
	.BURST_CYCLES(BURST_CYCLES),
	.SETTLE_HALF (SETTLE_HALF)
) u_chk (
	.mclk_i, .srst_i, .drain_sense_inputs_i, .half_cycle_end_i,
	.supply_ok_i, .en_strap_i, .sel_strap_i, .remote_off_i,
	.gate_drive_en_o, .low_power_o, .en_source_startup_o,
	.en_source_run_o, .select_pin_source_current_o, .sleep_enabled_o,
	.sleep_entry_duty_o, .burst_exit_duty_o
);

`default_nettype wire

/* File: bsc_burst_ctrl_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module bsc_burst_ctrl_tb_top
	import bsc_pkg::*;
();
	localparam int BURST  = 20;
	localparam int SETTLE = 4;
	logic        mclk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        sw     = 1'b1;
	logic        supply = 1'b0;
	logic        r_off  = 1'b0;
	logic        r_on   = 1'b0;
	logic        slp    = 1'b0;
	logic [6:0]  duty   = 7'd90;
	logic [1:0]  en_s   = 2'h0;
	logic [1:0]  sel_s  = 2'h0;
	logic        cyc    = 1'b0;
	logic        we     = 1'b0;
	logic [7:0]  adr    = 8'h00;
	logic [31:0] wdat   = 32'h0;
	logic [31:0] rdat;
	logic [31:0] dat;
	logic [1:0]  drain;
	logic [6:0]  entry;
	logic [6:0]  ex;
	logic        cond, hend, gate, lowp, s_st, s_run, s_sel, slp_en, ack;
	int          miscompares = 0;
	int          n_tests = 0;
	int          cycles = 0;
	int          n, t90, t100;

	always #10 mclk_i = ~mclk_i;

	bsc_primary_model u_pri (.mclk_i(mclk_i), .switching_i(sw),
		.duty_i(duty), .drain_o(drain), .conduct_o(cond), .half_end_o(hend));

	bsc_burst_ctrl #(.BURST_CYCLES(BURST), .SETTLE_HALF(SETTLE)) dut (
		.mclk_i(mclk_i), .srst_i(srst_i), .drain_sense_inputs_i(drain),
		.conduct_i(cond), .half_cycle_end_i(hend), .supply_ok_i(supply),
		.en_strap_i(en_s), .sel_strap_i(sel_s), .remote_off_i(r_off),
		.remote_on_i(r_on), .sleep_request_i(slp), .gate_drive_en_o(gate),
		.low_power_o(lowp), .en_source_startup_o(s_st),
		.en_source_run_o(s_run), .select_pin_source_current_o(s_sel),
		.sleep_enabled_o(slp_en), .sleep_entry_duty_o(entry),
		.burst_exit_duty_o(ex), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(dat), .wb_ack_o(ack));

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		cyc  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do @(posedge mclk_i); while (ack !== 1'b1);
		rdat = dat;
		cyc <= 1'b0;
		we  <= 1'b0;
	endtask
	task automatic wait_gate(input logic want, input int lim, output int k);
		k = 0;
		while (gate !== want && k < lim) begin
			@(posedge mclk_i);
			k++;
		end
	endtask
	task automatic cfg(input logic [1:0] e, input logic [1:0] s);
		@(posedge mclk_i);
		supply <= 1'b0;
		@(posedge mclk_i);
		en_s   <= e;
		sel_s  <= s;
		r_off  <= 1'b0; // Pull-down kept off while straps are read
		supply <= 1'b1;
		repeat (3) @(posedge mclk_i);
	endtask
	function automatic logic [6:0] exp_exit(input int e, input int s);
		logic [6:0] b;
		b = (s == 0) ? 7'd80 : (s == 1) ? 7'd75 : (s == 2) ? 7'd65 : 7'd60;
		if (e >= 2 && s == 3)
			return 7'd0;
		return (e == 1) ? b - 7'd5 : b;
	endfunction

	// Hang guard, well above the few thousand cycles the run needs
	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			end_sim();
		end
	end

	// ------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (20) @(posedge mclk_i);
		srst_i <= 1'b0;
		check({gate, lowp, s_st, s_run, s_sel}, 32'h5);
		for (int e = 0; e < 4; e++) begin
			for (int s = 0; s < 4; s++) begin
				cfg(e[1:0], s[1:0]);
				check(ex, exp_exit(e, s));
				check(slp_en, e < 2);
				check(entry, e == 0 ? 40 : e == 1 ? 25 : 0);
				check({s_st, s_run, s_sel}, 32'h2);
			end
		end
		en_s  <= 2'h0;
		sel_s <= 2'h0;
		repeat (5) @(posedge mclk_i);
		check({slp_en, ex}, 32'h0);
		$display("test strap table done");
		slp <= 1'b1;
		repeat (100) @(posedge mclk_i);
		check(gate, 1'b1);
		slp <= 1'b0;
		// Two short pauses, together longer than the window
		repeat (2) begin
			sw <= 1'b0;
			repeat (BURST - 5) @(posedge mclk_i);
			sw <= 1'b1;
			repeat (60) @(posedge mclk_i);
			check(gate, 1'b1);
		end
		$display("test sleep disabled done");
		cfg(2'h0, 2'h0);
		wb(1'b0, 8'h04, 32'h0);
		check(rdat, 32'h0050_2832);
		wb(1'b1, 8'h04, 32'hffff_ffff);
		wb(1'b0, 8'h04, 32'h0);
		check(rdat, 32'h0050_2832);
		wb(1'b0, 8'h00, 32'h0);
		check(rdat, 32'h0000_4000);
		wb(1'b0, 8'h0c, 32'h0);
		check(rdat, 32'h0);
		wb(1'b0, 8'h08, 32'h0);
		check(rdat[6:0], 7'd90);
		$display("test registers done");
		slp <= 1'b1;
		wait_gate(1'b0, 10, n);
		check(lowp, 1'b1);
		slp <= 1'b0;
		wait_gate(1'b1, 1000, n);
		check(gate, 1'b1);
		$display("test sleep request done");
		sw <= 1'b0;
		wait_gate(1'b0, BURST + 10, n);
		check(lowp, 1'b1);
		check(n >= BURST - 1, 1'b1);
		duty <= 7'd70;
		sw   <= 1'b1;
		repeat (400) @(posedge mclk_i);
		check(lowp, 1'b1);
		duty <= 7'd90;
		wait_gate(1'b1, 1000, t90);
		sw <= 1'b0;
		wait_gate(1'b0, BURST + 10, n);
		duty <= 7'd100;
		sw   <= 1'b1;
		wait_gate(1'b1, 1000, t100);
		check(gate, 1'b1);
		check(t100 < t90, 1'b1);
		$display("test burst exit done");
		r_off <= 1'b1;
		wait_gate(1'b0, 10, n);
		check(lowp, 1'b1);
		r_off <= 1'b0;
		r_on  <= 1'b1;
		wait_gate(1'b1, 1000, n);
		check(gate, 1'b1);
		r_on <= 1'b0;
		$display("test remote done");
		wb(1'b1, 8'h00, 32'h0000_4001);
		wait_gate(1'b0, 10, n);
		check(lowp, 1'b1);
		wb(1'b1, 8'h00, 32'h0000_4000);
		wait_gate(1'b1, 1000, n);
		check(gate, 1'b1);
		$display("test soft off done");
		end_sim();
	end
endmodule

`default_nettype wire

/* File: bsc_cfg.svh */
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BSC_CLK_MHZ          50
`define BSC_BURST_TIME_US    20
`define BSC_BURST_CYCLES     (`BSC_BURST_TIME_US * `BSC_CLK_MHZ)
`define BSC_SETTLE_SWITCH    12
`define BSC_SETTLE_HALF      (2 * `BSC_SETTLE_SWITCH)

// ----------------------------------------------------------------------
// Duty thresholds in percent
// ----------------------------------------------------------------------
`define BSC_ENTRY_LOW_RES    7'd40
`define BSC_ENTRY_HIGH_RES   7'd25
`define BSC_EXIT_A_SHORT     7'd80
`define BSC_EXIT_A_100K      7'd75
`define BSC_EXIT_A_180K      7'd65
`define BSC_EXIT_A_OPEN      7'd60
`define BSC_EXIT_B_SHORT     7'd75
`define BSC_EXIT_B_100K      7'd70
`define BSC_EXIT_B_180K      7'd60
`define BSC_EXIT_B_OPEN      7'd55
`define BSC_EXIT_D_SHORT     7'd80
`define BSC_EXIT_D_100K      7'd75
`define BSC_EXIT_D_180K      7'd65
`define BSC_EXIT_D_OPEN      7'd0
`define BSC_PERCENT_FULL     7'd100

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define BSC_ADR_CTRL         8'h00
`define BSC_ADR_STATUS       8'h04
`define BSC_ADR_DUTY         8'h08
`define BSC_CTRL_SOFT_OFF    0
`define BSC_CTRL_CREDIT_LSB  8
`define BSC_CTRL_CREDIT_MSB  15
`define BSC_CREDIT_RESET     8'h40

`endif

/* File: bsc_duty_meter.sv */
`timescale 1ns/100ps
`default_nettype none

`include "bsc_cfg.svh"

module bsc_duty_meter
	import bsc_pkg::*;
#(
	parameter int CW = 12
) (
	input  wire logic  mclk_i,
	input  wire logic  srst_i,
	bsc_meter_if.meter m
);
	logic [CW-1:0]   period_cnt;
	logic [CW-1:0]   cond_cnt;
	logic [CW+6:0]   rem;
	logic [CW-1:0]   div;
	logic [6:0]      quot;
	logic [2:0]      bit_idx;
	logic            busy;
	logic [CW+6:0]   trial;

	// ------------------------------------------------------------------
	// Per half-cycle counters, saturating
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			period_cnt <= '0;
			cond_cnt   <= '0;
		end else if (m.cycle_end) begin
			// End cycle opens the next window, so no cycle is lost
			period_cnt <= CW'(1);
			cond_cnt   <= CW'(m.conduct);
		end else begin
			if (period_cnt != {CW{1'b1}})
				period_cnt <= period_cnt + 1'b1;
			if (m.conduct && cond_cnt != {CW{1'b1}})
				cond_cnt <= cond_cnt + 1'b1;
		end
	end

	assign trial = {7'h00, div} << bit_idx;

	// ------------------------------------------------------------------
	// Seven step restoring divide of cond*100 by period
	// ------------------------------------------------------------------
	// A new cycle end during a divide restarts it; the old one is lost
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rem          <= '0;
			div          <= '0;
			quot         <= '0;
			bit_idx      <= '0;
			busy         <= 1'b0;
			m.duty_pct   <= '0;
			m.duty_valid <= 1'b0;
		end else begin
			m.duty_valid <= 1'b0;
			if (m.cycle_end) begin
				rem     <= (CW+7)'(cond_cnt) * (CW+7)'(`BSC_PERCENT_FULL);
				div     <= (period_cnt == '0) ? CW'(1) : period_cnt;
				quot    <= '0;
				bit_idx <= 3'h6;
				busy    <= 1'b1;
			end else if (busy) begin
				if (rem >= trial) begin
					rem           <= rem - trial;
					quot[bit_idx] <= 1'b1;
				end
				if (bit_idx == 3'h0) begin
					busy         <= 1'b0;
					m.duty_valid <= 1'b1;
					if (rem >= trial)
						m.duty_pct <= clamp(quot | 7'h01);
					else
						m.duty_pct <= clamp(quot);
				end else begin
					bit_idx <= bit_idx - 1'b1;
				end
			end
		end
	end

	function automatic logic [6:0] clamp(input logic [6:0] q);
		return (q > `BSC_PERCENT_FULL) ? `BSC_PERCENT_FULL : q;
	endfunction

endmodule

`default_nettype wire

/* File: bsc_meter_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface bsc_meter_if;
	logic       conduct;
	logic       cycle_end;
	logic [6:0] duty_pct;
	logic       duty_valid;

	modport meter (input conduct, input cycle_end,
		output duty_pct, output duty_valid);
	modport ctrl (output conduct, output cycle_end,
		input duty_pct, input duty_valid);
endinterface

`default_nettype wire

/* File: bsc_pkg.sv */
package bsc_pkg;

	typedef enum logic [3:0] {
		s_startup = 4'h1,
		s_run     = 4'h2,
		s_low     = 4'h4,
		s_settle  = 4'h8
	} bsc_state_type;

	// Remote pin strap as quantised at startup
	typedef enum logic [1:0] {
		en_low_res  = 2'h0,
		en_high_res = 2'h1,
		en_open     = 2'h2
	} bsc_en_strap_type;

	// Threshold select pin strap as quantised at startup
	typedef enum logic [1:0] {
		sel_short = 2'h0,
		sel_100k  = 2'h1,
		sel_180k  = 2'h2,
		sel_open  = 2'h3
	} bsc_sel_strap_type;

endpackage

/* File: bsc_primary_model.sv */
`timescale 1ns/100ps
`default_nettype none

module bsc_primary_model #(
	parameter int HALF = 20
) (
	input  wire logic       mclk_i,
	input  wire logic       switching_i,
	input  wire logic [6:0] duty_i,
	output logic [1:0]      drain_o,
	output logic            conduct_o,
	output logic            half_end_o
);
	int   ph;
	logic side = 1'b0;

	always_ff @(posedge mclk_i) begin
		if (!switching_i) begin
			ph <= 0;
		end else begin
			ph <= (ph == HALF - 1) ? 0 : ph + 1;
			if (ph == HALF - 1)
				side <= !side;
		end
	end
	// Idle bursts: both drains ring up high, kept long by bench
	assign drain_o    = !switching_i ? 2'h3 : (side ? 2'h1 : 2'h2);
	assign conduct_o  = switching_i && ph < int'(duty_i) * HALF / 100;
	assign half_end_o = switching_i && ph == HALF - 1;
endmodule

`default_nettype wire
